// ---- src/bmp_regs.vh ----
// Register offsets, field positions and reset values of the priority block.
`ifndef BMP_REGS_VH
`define BMP_REGS_VH

// Byte addresses of the two priority control registers.
`define BMP_ADDR_FIRST 32'h01C4003C
`define BMP_ADDR_SECOND 32'h01C40040

// Reset value of the first register.
`define BMP_FIRST_RESET 32'h00000000

// Field positions (low bit) inside the second register.
`define BMP_POS_VID_TC 0
`define BMP_POS_HOST_EMAC 4
`define BMP_POS_USB_DSPCFG 8
`define BMP_POS_DISK 12
`define BMP_POS_LINK_IMG 16
`define BMP_POS_RSVD_HI 19

// Width of one priority field.
`define BMP_PRIO_W 3

// Reset priorities per group.
`define BMP_RST_VID_TC 3'h0
`define BMP_RST_OTHER 3'h4
`define BMP_RST_DSP_DMA 3'h7

// Read value of the reserved bits 23:19.
`define BMP_RSVD_HI_VAL 5'h08

// Number of bus masters.
`define BMP_NUM_MASTERS 12

`endif

// ---- src/bmp_prio_field.v ----
// One programmable 3-bit priority field with its own reset value.
`timescale 1ns/100ps
module bmp_prio_field
#(
   parameter [2:0] RESET_VAL = 3'h4
)
(
   // Clock and reset
   input wire mclk,
   input wire rst,
   // Write side
   input wire we,
   input wire [2:0] wdata,
   // Field value
   output reg [2:0] prio_q
);

   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         prio_q <= RESET_VAL;
      end
      else if (we)
      begin
         prio_q <= wdata;
      end
   end

endmodule

// ---- src/bmp_arbiter.v ----
// Fixed-priority arbiter where the numerically lowest priority value wins.
`timescale 1ns/100ps
module bmp_arbiter
#(
   parameter N = 12
)
(
   // Clock and reset
   input wire mclk,
   input wire rst,
   // Requests and per-master priorities
   input wire [N-1:0] req,
   input wire [3*N-1:0] prio,
   // Registered one-hot grant
   output reg [N-1:0] grant_q
);

   reg [N-1:0] grant_d;
   reg [2:0] best;
   reg found;
   integer i;

   // Lowest value wins; on a tie the lowest master index wins.
   always @*
   begin
      grant_d = {N{1'b0}};
      best = 3'h7;
      found = 1'b0;
      for (i = 0; i < N; i = i + 1)
      begin
         if (req[i] && (!found || prio[3*i +: 3] < best))
         begin
            best = prio[3*i +: 3];
            found = 1'b1;
            grant_d = {N{1'b0}};
            grant_d[i] = 1'b1;
         end
      end
   end

   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         grant_q <= {N{1'b0}};
      end
      else
      begin
         grant_q <= grant_d;
      end
   end

endmodule

// ---- src/bmp_priority_config.v ----
// Bus master priority registers, per-master priority outputs and arbiter.
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/100ps
`include "bmp_regs.vh"

// Notes on behaviour
// - Two 32-bit priority registers sit at 0x01C4003C and 0x01C40040.
// - The first register stores writes but never changes any master priority.
// - The second register sets priority of every master except DSP DMA, which stays fixed at 7.
// - Reset loads the revised per-master default priorities.
// - Defaults: video and both transfer controllers 0, DSP DMA 7, others 4.
module bmp_priority_config
(
   // Clock and reset
   input wire mclk,
   input wire rst,
   // Wishbone classic slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [31:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // Per-master priorities to the interconnect
   output reg [2:0] video_subsystem_master_prio_q,
   output reg [2:0] transfer_controller_zero_prio_q,
   output reg [2:0] transfer_controller_one_prio_q,
   output reg [2:0] host_dma_prio_q,
   output reg [2:0] host_cfg_prio_q,
   output reg [2:0] dsp_dma_prio_q,
   output reg [2:0] dsp_cfg_prio_q,
   output reg [2:0] emac_prio_q,
   output reg [2:0] usb_prio_q,
   output reg [2:0] disk_interface_prio_q,
   output reg [2:0] serial_link_prio_q,
   output reg [2:0] imaging_coproc_prio_q,
   // Arbitration requests and registered grant
   input wire [11:0] master_req,
   output wire [11:0] master_grant_q
);

   localparam NM = `BMP_NUM_MASTERS;

   // Merges write data into an old word under the byte selects.
   function [31:0] merge_sel;
      input [31:0] old;
      input [31:0] wdat;
      input [3:0] sel;
      integer b;
      begin
         merge_sel = old;
         for (b = 0; b < 4; b = b + 1)
         begin
            if (sel[b])
            begin
               merge_sel[8*b +: 8] = wdat[8*b +: 8];
            end
         end
      end
   endfunction

   // Picks one 3-bit priority field out of a register word.
   function [2:0] field_at;
      input [31:0] word;
      input integer pos;
      begin
         field_at = word[pos +: 3];
      end
   endfunction

   // Bus request decode.
   wire req_valid;
   wire wr_take;
   wire wr_first;
   wire wr_second;
   wire hit_first;
   wire hit_second;
   wire [31:0] wdat_second;

   // First register and the fields of the second.
   reg [31:0] first_q;
   wire [2:0] vid_tc_q;
   wire [2:0] host_emac_q;
   wire [2:0] usb_dspcfg_q;
   wire [2:0] disk_q;
   wire [2:0] link_img_q;
   wire [31:0] second_rd;

   // Combined priority vector feeding the arbiter.
   wire [3*NM-1:0] prio_vec;

   // Read data and acknowledge next values.
   reg [31:0] wb_dat_d;
   reg wb_ack_d;

   // A request is taken once; ack drops in the cycle after it was given.
   assign req_valid = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_take = req_valid & wb_we_i;
   assign hit_first = (wb_adr_i == `BMP_ADDR_FIRST);
   assign hit_second = (wb_adr_i == `BMP_ADDR_SECOND);
   assign wr_first = wr_take & hit_first;
   assign wr_second = wr_take & hit_second;

   // Bytes not selected keep their current value.
   assign wdat_second = merge_sel(second_rd, wb_dat_i, wb_sel_i);

   // Read view of the second register, reserved bits as fixed.
   assign second_rd =
      {8'h00,
       `BMP_RSVD_HI_VAL,
       link_img_q,
       1'b0,
       disk_q,
       1'b0,
       usb_dspcfg_q,
       1'b0,
       host_emac_q,
       1'b0,
       vid_tc_q};

   // The first register only stores; nothing below reads it for priority.
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         first_q <= `BMP_FIRST_RESET;
      end
      else if (wr_first)
      begin
         first_q <= merge_sel(first_q, wb_dat_i, wb_sel_i);
      end
   end

   // Priority fields of the second register.
   bmp_prio_field
   #(
      .RESET_VAL(`BMP_RST_VID_TC)
   )
   u_vid_tc
   (
      .mclk(mclk),
      .rst(rst),
      .we(wr_second),
      .wdata(field_at(wdat_second, `BMP_POS_VID_TC)),
      .prio_q(vid_tc_q)
   );

   bmp_prio_field
   #(
      .RESET_VAL(`BMP_RST_OTHER)
   )
   u_host_emac
   (
      .mclk(mclk),
      .rst(rst),
      .we(wr_second),
      .wdata(field_at(wdat_second, `BMP_POS_HOST_EMAC)),
      .prio_q(host_emac_q)
   );

   bmp_prio_field
   #(
      .RESET_VAL(`BMP_RST_OTHER)
   )
   u_usb_dspcfg
   (
      .mclk(mclk),
      .rst(rst),
      .we(wr_second),
      .wdata(field_at(wdat_second, `BMP_POS_USB_DSPCFG)),
      .prio_q(usb_dspcfg_q)
   );

   bmp_prio_field
   #(
      .RESET_VAL(`BMP_RST_OTHER)
   )
   u_disk
   (
      .mclk(mclk),
      .rst(rst),
      .we(wr_second),
      .wdata(field_at(wdat_second, `BMP_POS_DISK)),
      .prio_q(disk_q)
   );

   bmp_prio_field
   #(
      .RESET_VAL(`BMP_RST_OTHER)
   )
   u_link_img
   (
      .mclk(mclk),
      .rst(rst),
      .we(wr_second),
      .wdata(field_at(wdat_second, `BMP_POS_LINK_IMG)),
      .prio_q(link_img_q)
   );

   // Per-master priorities other than DSP DMA follow the second register one cycle later.
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         video_subsystem_master_prio_q <= `BMP_RST_VID_TC;
         transfer_controller_zero_prio_q <= `BMP_RST_VID_TC;
         transfer_controller_one_prio_q <= `BMP_RST_VID_TC;
         host_dma_prio_q <= `BMP_RST_OTHER;
         host_cfg_prio_q <= `BMP_RST_OTHER;
         dsp_dma_prio_q <= `BMP_RST_DSP_DMA;
         dsp_cfg_prio_q <= `BMP_RST_OTHER;
         emac_prio_q <= `BMP_RST_OTHER;
         usb_prio_q <= `BMP_RST_OTHER;
         disk_interface_prio_q <= `BMP_RST_OTHER;
         serial_link_prio_q <= `BMP_RST_OTHER;
         imaging_coproc_prio_q <= `BMP_RST_OTHER;
      end
      else
      begin
         video_subsystem_master_prio_q <= vid_tc_q;
         transfer_controller_zero_prio_q <= vid_tc_q;
         transfer_controller_one_prio_q <= vid_tc_q;
         host_dma_prio_q <= host_emac_q;
         host_cfg_prio_q <= host_emac_q;
         dsp_dma_prio_q <= `BMP_RST_DSP_DMA;
         dsp_cfg_prio_q <= usb_dspcfg_q;
         emac_prio_q <= host_emac_q;
         usb_prio_q <= usb_dspcfg_q;
         disk_interface_prio_q <= disk_q;
         serial_link_prio_q <= link_img_q;
         imaging_coproc_prio_q <= link_img_q;
      end
   end

   // Master index order: video, tc0, tc1, host dma, host cfg, dsp dma,
   // dsp cfg, emac, usb, disk, serial link, imaging.
   assign prio_vec =
      {imaging_coproc_prio_q,
       serial_link_prio_q,
       disk_interface_prio_q,
       usb_prio_q,
       emac_prio_q,
       dsp_cfg_prio_q,
       dsp_dma_prio_q,
       host_cfg_prio_q,
       host_dma_prio_q,
       transfer_controller_one_prio_q,
       transfer_controller_zero_prio_q,
       video_subsystem_master_prio_q};

   bmp_arbiter
   #(
      .N(NM)
   )
   u_arb
   (
      .mclk(mclk),
      .rst(rst),
      .req(master_req),
      .prio(prio_vec),
      .grant_q(master_grant_q)
   );

   // Read mux; unmapped addresses answer with zero.
   always @*
   begin
      wb_ack_d = req_valid;
      wb_dat_d = 32'h00000000;
      if (req_valid && !wb_we_i)
      begin
         case ({hit_second, hit_first})
            2'b01:
            begin
               wb_dat_d = first_q;
            end
            2'b10:
            begin
               wb_dat_d = second_rd;
            end
            default:
            begin
               wb_dat_d = 32'h00000000;
            end
         endcase
      end
   end

   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         wb_ack_o <= wb_ack_d;
         wb_dat_o <= wb_dat_d;
      end
   end

endmodule

// ---- sim/bmp_priority_props.sv ----
// Checker for the bus master priority block.
`timescale 1ns/100ps
`include "bmp_regs.vh"
module bmp_priority_props
(
   // Clock and reset
   input wire mclk,
   input wire rst,
   // Register bus
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [31:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire wb_ack_o,
   // Priorities and arbitration
   input wire [2:0] dsp_dma_prio_q,
   input wire [2:0] usb_prio_q,
   input wire [11:0] master_req,
   input wire [11:0] master_grant_q
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   wire tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire [2:0] usb_w = wb_dat_i[10:8];
   AST_ACK: assert property (tk |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack is not a single pulse");
   AST_FIRST: assert property (tk && wb_we_i &&
      wb_adr_i == `BMP_ADDR_FIRST |=> $stable(usb_prio_q) [*2])
      else $error("first register changed a priority");
   AST_SECOND: assert property (tk && wb_we_i && wb_sel_i[1] &&
      wb_adr_i == `BMP_ADDR_SECOND |-> ##2 usb_prio_q == $past(usb_w, 2))
      else $error("second register did not set usb priority");
   AST_DSP: assert property (dsp_dma_prio_q == `BMP_RST_DSP_DMA)
      else $error("dsp dma priority not fixed");
   AST_RST: assert property ($fell(rst) |-> usb_prio_q == `BMP_RST_OTHER)
      else $error("usb default priority wrong");
   AST_WIN: assert property (master_req == 12'h120 |=>
      master_grant_q[8] == ($past(usb_prio_q) < 3'h7))
      else $error("wrong winner");
   AST_ONE: assert property ($onehot0(master_grant_q))
      else $error("grant not one-hot");
   AST_IDLE: assert property (master_req == 12'h000 |=>
      master_grant_q == 12'h000)
      else $error("grant without request");
endmodule
bind bmp_priority_config bmp_priority_props u_props (.mclk(mclk),
   .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_ack_o(wb_ack_o), .dsp_dma_prio_q(dsp_dma_prio_q),
   .usb_prio_q(usb_prio_q), .master_req(master_req),
   .master_grant_q(master_grant_q));

// ---- sim/bmp_req_model.sv ----
// Requesting masters of the interconnect, driving request levels.
`timescale 1ns/100ps
module bmp_req_model
(
   // Clock and reset
   input wire mclk,
   input wire rst,
   // Wanted and driven requests
   input wire [11:0] want,
   output reg [11:0] master_req
);
   always @(posedge mclk or posedge rst)
      if (rst)
         master_req <= 12'h000;
      else
         master_req <= want;
endmodule

// ---- sim/tb.sv ----
// Testbench for the bus master priority block.
`timescale 1ns/100ps
`include "bmp_regs.vh"
module tb;
   reg mclk = 1'b0;
   reg rst = 1'b1;
   reg cyc = 1'b0;
   reg stb = 1'b0;
   reg we = 1'b0;
   reg [31:0] adr = 32'h0;
   reg [31:0] dat = 32'h0;
   reg [3:0] sel = 4'h0;
   reg [11:0] want = 12'h000;
   reg [31:0] q;
   wire [31:0] rd;
   wire ack;
   wire [11:0] req;
   wire [11:0] gnt;
   wire [35:0] pr;
   integer errors = 0;
   integer n_compared = 0;
   initial forever #50 mclk = ~mclk;
   bmp_req_model u_req (.mclk(mclk), .rst(rst), .want(want),
      .master_req(req));
   bmp_priority_config uut (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
      .video_subsystem_master_prio_q(pr[35:33]),
      .transfer_controller_zero_prio_q(pr[32:30]),
      .transfer_controller_one_prio_q(pr[29:27]),
      .host_dma_prio_q(pr[26:24]), .host_cfg_prio_q(pr[23:21]),
      .dsp_dma_prio_q(pr[20:18]), .dsp_cfg_prio_q(pr[17:15]),
      .emac_prio_q(pr[14:12]), .usb_prio_q(pr[11:9]),
      .disk_interface_prio_q(pr[8:6]), .serial_link_prio_q(pr[5:3]),
      .imaging_coproc_prio_q(pr[2:0]), .master_req(req),
      .master_grant_q(gnt));
   task final_report;
      begin
         $display("compared %0d errors %0d", n_compared, errors);
         if (errors == 0 && n_compared > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   task chk(input string nm, input [35:0] e, input [35:0] g);
      begin
         n_compared = n_compared + 1;
         if (g !== e)
         begin
            errors = errors + 1;
            $display("wrong value %s exp %h got %h", nm, e, g);
         end
      end
   endtask
   task wb(input [31:0] a, input w, input [3:0] s, input [31:0] d);
      integer i;
      begin
         @(posedge mclk);
         cyc <= 1'b1;
         stb <= 1'b1;
         we <= w;
         adr <= a;
         sel <= s;
         dat <= d;
         i = 0;
         @(posedge mclk);
         while (ack !== 1'b1 && i < 20)
         begin
            @(posedge mclk);
            i = i + 1;
         end
         q = rd;
         cyc <= 1'b0;
         stb <= 1'b0;
         if (ack !== 1'b1)
         begin
            errors = errors + 1;
            final_report;
         end
      end
   endtask
   task gr(input [11:0] w, input [11:0] e);
      begin
         @(posedge mclk);
         want <= w;
         repeat (3) @(posedge mclk);
         #1;
         chk("grant", e, gnt);
      end
   endtask
   initial
   begin
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      #1;
      chk("prio", 36'h0049E4924, pr);
      wb(`BMP_ADDR_FIRST, 1'b0, 4'hF, 32'h0);
      chk("first", 32'h0, q);
      wb(`BMP_ADDR_SECOND, 1'b0, 4'hF, 32'h0);
      chk("second", 32'h00444440, q);
      wb(`BMP_ADDR_FIRST, 1'b1, 4'hF, 32'hFFFFFFFF);
      #1;
      chk("prio", 36'h0049E4924, pr);
      wb(`BMP_ADDR_FIRST, 1'b0, 4'hF, 32'h0);
      chk("first", 32'hFFFFFFFF, q);
      wb(`BMP_ADDR_SECOND, 1'b1, 4'hF, 32'h00777777);
      wb(`BMP_ADDR_SECOND, 1'b1, 4'h2, 32'h00007300);
      #1;
      chk("prio", {18'h3FFFF, 3'h3, 3'h7, 3'h3, 9'h1FF}, pr);
      wb(32'h01C40044, 1'b1, 4'hF, 32'h0);
      wb(32'h01C40044, 1'b0, 4'hF, 32'h0);
      chk("unmapped", 32'h0, q);
      wb(`BMP_ADDR_SECOND, 1'b0, 4'hF, 32'h0);
      chk("second", 32'h00477377, q);
      gr(12'h120, 12'h100);
      wb(`BMP_ADDR_SECOND, 1'b1, 4'h2, 32'h00007700);
      gr(12'h120, 12'h020);
      gr(12'h000, 12'h000);
      @(posedge mclk);
      rst <= 1'b1;
      @(posedge mclk);
      rst <= 1'b0;
      #1;
      chk("prio", 36'h0049E4924, pr);
      wb(`BMP_ADDR_FIRST, 1'b0, 4'hF, 32'h0);
      chk("first", 32'h0, q);
      wb(`BMP_ADDR_SECOND, 1'b0, 4'hF, 32'h0);
      chk("second", 32'h00444440, q);
      final_report;
   end
endmodule
